// ### rtl/fbdm_pkg.sv
package fbdm_pkg;
    // ==========================================
    // local port map
    localparam logic [31:0] BUF_BASE = 32'hff880000;
    localparam logic [31:0] BUF_LAST = 32'hff883fff;
    localparam logic [31:0] REG_BASE = 32'hff803800;
    localparam int BUF_AW = 14;
    localparam int BUF_DEPTH = 16384;
    localparam int DW = 8;
    localparam logic [2:0] OFF_STAT = 3'h0;
    localparam logic [2:0] OFF_OPER = 3'h3;
    localparam logic [2:0] OFF_DMA = 3'h4;
    localparam logic [2:0] OFF_TC = 3'h5;
    localparam logic [7:0] DMA_RESET = 8'hfc;
    localparam int DIR_BIT = 0;
    localparam int BUSY_BIT = 1;
    // ==========================================
    // controller registers on axi4-lite
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_ADDR = 5'h04;
    localparam logic [4:0] A_WDATA = 5'h08;
    localparam logic [4:0] A_STATUS = 5'h0c;
    localparam logic [4:0] A_IRQ_STAT = 5'h10;
    localparam logic [4:0] A_IRQ_MASK = 5'h14;
    localparam int CTRL_GO = 0;
    localparam int CTRL_WE = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_RD_LSB = 8;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_FDC = 1;
    localparam int IRQ_W = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // states
    typedef enum logic [2:0] {
        P_IDLE = 3'b001,
        P_SERVE = 3'b010,
        P_ACK = 3'b100
    } fbdm_port_st_t;
    typedef enum logic [2:0] {
        D_IDLE = 3'b001,
        D_XFER = 3'b010,
        D_WAIT = 3'b100
    } fbdm_dma_st_t;
endpackage : fbdm_pkg

// ### rtl/fbdm_lport_if.sv
// byte-wide local i/o port between processor side and data manager
interface fbdm_lport_if (
    input wire logic aclk,
    input wire logic aresetn
);
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic ack;
    logic [7:0] rdata;
    logic irq1;

    modport dev (
        input aclk, aresetn, req, we, addr, wdata,
        output ack, rdata, irq1
    );
    modport host (
        input aclk, aresetn, ack, rdata, irq1,
        output req, we, addr, wdata
    );
endinterface : fbdm_lport_if

// ### rtl/fbdm_device.sv
// The AXI4-Lite slave port was decided locally.
module fbdm_device (
    // local port
    fbdm_lport_if.dev lp,
    // floppy controller chip
    output logic fdc_cs,
    output logic fdc_rd,
    output logic fdc_wr,
    output logic [1:0] fdc_a,
    input wire logic [7:0] fdc_d_i,
    output logic [7:0] fdc_d_o,
    output logic fdc_d_oe,
    input wire logic fdc_drq,
    output logic fdc_dack,
    output logic terminal_count_strobe,
    input wire logic fdc_int
);
    // clock and reset arrive through the local port
    logic aclk;
    logic aresetn;
    assign aclk = lp.aclk;
    assign aresetn = lp.aresetn;

    // ==========================================
    // decode
    function automatic logic at_reg(input logic [31:0] a,
                                    input logic [2:0] off);
        at_reg = (a == fbdm_pkg::REG_BASE + {29'h0, off});
    endfunction

    logic [7:0] mem [fbdm_pkg::BUF_DEPTH];
    fbdm_pkg::fbdm_port_st_t pst_q;
    fbdm_pkg::fbdm_dma_st_t dst_q;
    logic dir_q;
    logic busy_q;
    logic [fbdm_pkg::BUF_AW-1:0] daddr_q;
    logic [7:0] dout_q;
    logic [7:0] rdata_q;
    logic fdc_int_q;
    logic is_buf, is_fdc, is_dma, is_tc;
    logic buf_free, serve_go, dma_take, dma_start;
    logic [fbdm_pkg::BUF_AW-1:0] cpu_baddr;

    assign is_buf = lp.addr >= fbdm_pkg::BUF_BASE &&
                    lp.addr <= fbdm_pkg::BUF_LAST;
    assign is_fdc = lp.addr >= fbdm_pkg::REG_BASE &&
                    lp.addr <= fbdm_pkg::REG_BASE +
                    {29'h0, fbdm_pkg::OFF_OPER};
    assign is_dma = at_reg(lp.addr, fbdm_pkg::OFF_DMA);
    assign is_tc = at_reg(lp.addr, fbdm_pkg::OFF_TC);
    assign cpu_baddr = lp.addr[fbdm_pkg::BUF_AW-1:0];

    // dma owns the buffer while a request is pending or in flight
    assign buf_free = dst_q != fbdm_pkg::D_XFER &&
                      !(dst_q == fbdm_pkg::D_IDLE && fdc_drq);
    assign serve_go = pst_q == fbdm_pkg::P_SERVE &&
                      (!is_buf || buf_free);
    assign dma_take = dst_q == fbdm_pkg::D_IDLE && fdc_drq;
    assign dma_start = dma_take && !busy_q;

    // ==========================================
    // processor access sequencing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pst_q <= fbdm_pkg::P_IDLE;
        end else begin
            case (pst_q)
                fbdm_pkg::P_IDLE: begin
                    if (lp.req) begin
                        pst_q <= fbdm_pkg::P_SERVE;
                    end
                end
                fbdm_pkg::P_SERVE: begin
                    if (serve_go) begin
                        pst_q <= fbdm_pkg::P_ACK;
                    end
                end
                fbdm_pkg::P_ACK: begin
                    pst_q <= fbdm_pkg::P_IDLE;
                end
                default: begin
                    pst_q <= fbdm_pkg::P_IDLE;
                end
            endcase
        end
    end

    assign lp.ack = pst_q == fbdm_pkg::P_ACK;
    assign lp.rdata = rdata_q;
    assign lp.irq1 = fdc_int;

    // read data for the processor
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_q <= 8'h00;
        end else if (serve_go && !lp.we) begin
            if (is_buf) begin
                rdata_q <= mem[cpu_baddr];
            end else if (is_fdc) begin
                rdata_q <= fdc_d_i;
            end else if (is_dma) begin
                rdata_q <= {fbdm_pkg::DMA_RESET[7:2], busy_q, dir_q};
            end else begin
                rdata_q <= 8'h00;
            end
        end
    end

    // ==========================================
    // dma control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_q <= fbdm_pkg::DMA_RESET[fbdm_pkg::DIR_BIT];
        end else if (serve_go && lp.we && is_dma) begin
            dir_q <= lp.wdata[fbdm_pkg::DIR_BIT];
        end
    end

    // busy from first request until the controller interrupts or the processor accesses the terminal count
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_q <= fbdm_pkg::DMA_RESET[fbdm_pkg::BUSY_BIT];
            fdc_int_q <= 1'b0;
        end else begin
            fdc_int_q <= fdc_int;
            if (dma_start) begin
                busy_q <= 1'b1;
            end else if ((fdc_int && !fdc_int_q) ||
                         (serve_go && is_tc)) begin
                busy_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // dma engine: one byte per request/acknowledge pair
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dst_q <= fbdm_pkg::D_IDLE;
        end else begin
            case (dst_q)
                fbdm_pkg::D_IDLE: begin
                    if (fdc_drq) begin
                        dst_q <= fbdm_pkg::D_XFER;
                    end
                end
                fbdm_pkg::D_XFER: begin
                    dst_q <= fbdm_pkg::D_WAIT;
                end
                fbdm_pkg::D_WAIT: begin
                    // controller drops its request after the acknowledge
                    if (!fdc_drq) begin
                        dst_q <= fbdm_pkg::D_IDLE;
                    end
                end
                default: begin
                    dst_q <= fbdm_pkg::D_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            daddr_q <= '0;
        end else if (dma_start) begin
            daddr_q <= '0;
        end else if (dst_q == fbdm_pkg::D_XFER) begin
            daddr_q <= daddr_q + 1'b1;
        end
    end

    // single-port buffer: dma write has priority over processor write
    always_ff @(posedge aclk) begin
        if (dst_q == fbdm_pkg::D_XFER && !dir_q) begin
            mem[daddr_q] <= fdc_d_i;
        end else if (serve_go && lp.we && is_buf) begin
            mem[cpu_baddr] <= lp.wdata;
        end
    end

    // byte driven toward the controller
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout_q <= 8'h00;
        end else if (dma_take) begin
            dout_q <= mem[dma_start ? '0 : daddr_q];
        end else if (pst_q == fbdm_pkg::P_IDLE && lp.req) begin
            dout_q <= lp.wdata;
        end
    end

    // ==========================================
    // controller pins
    logic fdc_acc;
    assign fdc_acc = pst_q != fbdm_pkg::P_IDLE && lp.req && is_fdc;
    assign fdc_cs = fdc_acc;
    assign fdc_rd = fdc_acc && !lp.we;
    assign fdc_wr = fdc_acc && lp.we;
    assign fdc_a = lp.addr[1:0];
    assign fdc_dack = dst_q == fbdm_pkg::D_XFER;
    assign fdc_d_o = dout_q;
    assign fdc_d_oe = (fdc_wr && !fdc_dack) ||
                      (fdc_dack && dir_q);
    // held across the whole access, dropped as it ends
    assign terminal_count_strobe = pst_q != fbdm_pkg::P_IDLE &&
                                   is_tc;
endmodule // fbdm_device

// ### rtl/fbdm_host.sv
module fbdm_host (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite slave
    input wire logic [4:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [4:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // interrupt
    output logic irq,
    // local port
    fbdm_lport_if.host lp
);
    logic [4:0] awaddr_q;
    logic aw_q, w_q;
    logic [31:0] wdata_q;
    // strobes are only valid with wvalid, so they are kept with the data
    logic [3:0] wstrb_q;
    logic [31:0] addr_q;
    logic [7:0] wbyte_q, rbyte_q;
    logic we_q, req_q;
    logic [fbdm_pkg::IRQ_W-1:0] ist_q, imask_q, iev, iclr;
    logic irq1_q;
    logic wr_do, go;

    // ==========================================
    // write channel: address and data taken in either order
    assign s_awready = !aw_q;
    assign s_wready = !w_q;
    assign wr_do = aw_q && w_q && !s_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 5'h00;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= fbdm_pkg::RESP_OKAY;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_q <= 1'b1;
                wdata_q <= s_wdata;
                wstrb_q <= s_wstrb;
            end
            if (wr_do) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_bvalid <= 1'b1;
                case (awaddr_q)
                    fbdm_pkg::A_CTRL, fbdm_pkg::A_ADDR,
                    fbdm_pkg::A_WDATA, fbdm_pkg::A_IRQ_STAT,
                    fbdm_pkg::A_IRQ_MASK: s_bresp <= fbdm_pkg::RESP_OKAY;
                    default: s_bresp <= fbdm_pkg::RESP_SLVERR;
                endcase
            end else if (s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // strobes are honoured on byte lane 0 only: every field fits there
    // except the address word, which takes all lanes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_q <= 32'h0;
            wbyte_q <= 8'h00;
            we_q <= 1'b0;
            imask_q <= '0;
        end else if (wr_do) begin
            for (int i = 0; i < 4; i++) begin
                if (awaddr_q == fbdm_pkg::A_ADDR && wstrb_q[i]) begin
                    addr_q[8*i +: 8] <= wdata_q[8*i +: 8];
                end
            end
            if (wstrb_q[0]) begin
                case (awaddr_q)
                    fbdm_pkg::A_WDATA: wbyte_q <= wdata_q[7:0];
                    fbdm_pkg::A_CTRL: we_q <= wdata_q[fbdm_pkg::CTRL_WE];
                    fbdm_pkg::A_IRQ_MASK:
                        imask_q <= wdata_q[fbdm_pkg::IRQ_W-1:0];
                    default: ;
                endcase
            end
        end
    end

    // ==========================================
    // local port master: one byte access per go
    assign go = wr_do && wstrb_q[0] && awaddr_q == fbdm_pkg::A_CTRL &&
                wdata_q[fbdm_pkg::CTRL_GO] && !req_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            req_q <= 1'b0;
            rbyte_q <= 8'h00;
        end else if (go) begin
            req_q <= 1'b1;
        end else if (req_q && lp.ack) begin
            req_q <= 1'b0;
            rbyte_q <= lp.rdata;
        end
    end
    assign lp.req = req_q;
    assign lp.we = we_q;
    assign lp.addr = addr_q;
    assign lp.wdata = wbyte_q;

    // ==========================================
    // interrupts: done and controller channel one, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq1_q <= 1'b0;
        end else begin
            irq1_q <= lp.irq1;
        end
    end
    assign iev[fbdm_pkg::IRQ_DONE] = req_q && lp.ack;
    assign iev[fbdm_pkg::IRQ_FDC] = lp.irq1 && !irq1_q;
    assign iclr = (wr_do && wstrb_q[0] &&
                   awaddr_q == fbdm_pkg::A_IRQ_STAT) ?
                  wdata_q[fbdm_pkg::IRQ_W-1:0] : '0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ist_q <= '0;
        end else begin
            ist_q <= (ist_q & ~iclr) | iev;
        end
    end
    assign irq = |(ist_q & imask_q);

    // ==========================================
    // read channel
    assign s_arready = !s_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= 32'h0;
            s_rresp <= fbdm_pkg::RESP_OKAY;
        end else if (s_arvalid && s_arready) begin
            s_rvalid <= 1'b1;
            s_rresp <= fbdm_pkg::RESP_OKAY;
            s_rdata <= 32'h0;
            case (s_araddr)
                fbdm_pkg::A_CTRL:
                    s_rdata[fbdm_pkg::CTRL_WE] <= we_q;
                fbdm_pkg::A_ADDR: s_rdata <= addr_q;
                fbdm_pkg::A_WDATA: s_rdata[7:0] <= wbyte_q;
                fbdm_pkg::A_STATUS: begin
                    s_rdata[fbdm_pkg::ST_BUSY] <= req_q;
                    s_rdata[fbdm_pkg::ST_RD_LSB +: 8] <= rbyte_q;
                end
                fbdm_pkg::A_IRQ_STAT:
                    s_rdata[fbdm_pkg::IRQ_W-1:0] <= ist_q;
                fbdm_pkg::A_IRQ_MASK:
                    s_rdata[fbdm_pkg::IRQ_W-1:0] <= imask_q;
                default: s_rresp <= fbdm_pkg::RESP_SLVERR;
            endcase
        end else if (s_rready) begin
            s_rvalid <= 1'b0;
        end
    end
endmodule // fbdm_host

// ### test/fbdm_lport_chk.sv
module fbdm_lport_chk (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // local port
    input wire logic req,
    input wire logic we,
    input wire logic [31:0] addr,
    input wire logic [7:0] wdata,
    input wire logic ack,
    input wire logic [7:0] rdata,
    input wire logic irq1
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ==========================================
    // local port handshake
    a_ack_pulse: assert property (ack |=> !ack)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (ack |-> req)
        else $error("ack without request");
    a_req_held: assert property (
        req && !ack |=> req && $stable(addr) && $stable(we)
            && $stable(wdata))
        else $error("request changed before ack");
    a_req_drop: assert property (ack |=> !req)
        else $error("request held after ack");
    a_ack_early: assert property ($rose(req) |-> !ack [*2])
        else $error("ack before serve cycle");
    // a dma byte may stall the processor, but never for long
    a_ack_bound: assert property ($rose(req) |-> ##[2:40] ack)
        else $error("ack late");
    a_rdata_hold: assert property (ack |=> $stable(rdata))
        else $error("read byte lost after ack");
    a_rdata_idle: assert property (!req && !ack |=> $stable(rdata))
        else $error("read byte changed while idle");
    c_write: cover property (ack && we);
    c_read: cover property (ack && !we);
    c_irq: cover property ($rose(irq1));
endmodule // fbdm_lport_chk

// ### test/tb_floppy_buffer_dma_manager.sv
module tb_floppy_buffer_dma_manager;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] RB = fbdm_pkg::REG_BASE;
    localparam logic [31:0] BB = fbdm_pkg::BUF_BASE;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [4:0] s_awaddr = '0;
    logic s_awvalid = 1'b0;
    logic [31:0] s_wdata = '0;
    logic [3:0] s_wstrb = 4'hf;
    logic s_wvalid = 1'b0;
    logic s_bready = 1'b0;
    logic [4:0] s_araddr = '0;
    logic s_arvalid = 1'b0;
    logic s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
    logic [1:0] s_bresp, s_rresp;
    logic [31:0] s_rdata;
    logic fdc_cs, fdc_rd, fdc_wr, fdc_d_oe, fdc_dack, terminal_count_strobe;
    logic [1:0] fdc_a;
    logic [7:0] fdc_d_i, fdc_d_o;
    logic fdc_drq = 1'b0;
    logic fdc_int = 1'b0;
    logic [7:0] fdc_byte = 8'h00;
    int tc_cnt = 0;
    logic [1:0] wr_a = '0;
    logic [7:0] wr_d = '0;
    logic [1:0] bresp_q;
    int errors = 0;
    int num_checks = 0;
    int cycles = 0;

    always #25 aclk = ~aclk;
    // controller answers reads and dma; off the bus it shows the inverse
    assign fdc_d_i = (fdc_rd | fdc_dack) ? fdc_byte : ~fdc_byte;

    fbdm_lport_if u_fbdm_lport_if (.aclk(aclk), .aresetn(aresetn));
    fbdm_host u_fbdm_host (.aclk(aclk), .aresetn(aresetn),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
        .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
        .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
        .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
        .s_rvalid(s_rvalid), .s_rready(s_rready), .irq(irq),
        .lp(u_fbdm_lport_if));
    fbdm_device u_fbdm_device (.lp(u_fbdm_lport_if), .fdc_cs(fdc_cs),
        .fdc_rd(fdc_rd), .fdc_wr(fdc_wr), .fdc_a(fdc_a), .fdc_d_i(fdc_d_i),
        .fdc_d_o(fdc_d_o), .fdc_d_oe(fdc_d_oe), .fdc_drq(fdc_drq),
        .fdc_dack(fdc_dack), .terminal_count_strobe(terminal_count_strobe),
        .fdc_int(fdc_int));
    fbdm_lport_chk u_fbdm_lport_chk (.aclk(aclk), .aresetn(aresetn),
        .req(u_fbdm_lport_if.req), .we(u_fbdm_lport_if.we),
        .addr(u_fbdm_lport_if.addr), .wdata(u_fbdm_lport_if.wdata),
        .ack(u_fbdm_lport_if.ack), .rdata(u_fbdm_lport_if.rdata),
        .irq1(u_fbdm_lport_if.irq1));

    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (terminal_count_strobe === 1'b1) tc_cnt <= tc_cnt + 1;
        if (fdc_cs === 1'b1 && fdc_wr === 1'b1) begin
            wr_a <= fdc_a;
            wr_d <= fdc_d_o;
        end
        if (cycles == 20000) begin
            errors = errors + 1;
            print_verdict();
        end
    end

    // ==========================================
    // bus tasks
    task automatic print_verdict();
        if (errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    // handshakes are judged just before the edge that takes them
    task automatic axi_write(input logic [4:0] a, input logic [31:0] d);
        logic aw, w, b;
        @(posedge aclk);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        forever begin
            @(negedge aclk);
            aw = s_awvalid && s_awready;
            w = s_wvalid && s_wready;
            b = s_bvalid === 1'b1;
            bresp_q = s_bresp;
            @(posedge aclk);
            if (aw) s_awvalid <= 1'b0;
            if (w) s_wvalid <= 1'b0;
            if (b) break;
        end
        s_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [4:0] a, output logic [31:0] d,
                            output logic [1:0] r);
        logic ar, rv;
        @(posedge aclk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        forever begin
            @(negedge aclk);
            ar = s_arvalid && s_arready;
            rv = s_rvalid === 1'b1;
            d = s_rdata;
            r = s_rresp;
            @(posedge aclk);
            if (ar) s_arvalid <= 1'b0;
            if (rv) break;
        end
        s_rready <= 1'b0;
    endtask

    task automatic loc(input logic w, input logic [31:0] a,
                       input logic [7:0] wd, output logic [7:0] rd);
        logic [31:0] v;
        logic [1:0] r;
        axi_write(fbdm_pkg::A_ADDR, a);
        axi_write(fbdm_pkg::A_WDATA, {24'h0, wd});
        v = '0;
        v[fbdm_pkg::CTRL_GO] = 1'b1;
        v[fbdm_pkg::CTRL_WE] = w;
        axi_write(fbdm_pkg::A_CTRL, v);
        forever begin
            axi_read(fbdm_pkg::A_STATUS, v, r);
            if (v[fbdm_pkg::ST_BUSY] === 1'b0) break;
        end
        rd = v[fbdm_pkg::ST_RD_LSB +: 8];
    endtask

    task automatic dma_byte(input logic [7:0] b, input logic wr_dir);
        @(posedge aclk);
        fdc_byte <= b;
        fdc_drq <= 1'b1;
        @(posedge aclk);
        #1;
        chk("dack", 32'h1, {31'h0, fdc_dack});
        if (wr_dir) chk("dma out", {23'h0, 1'b1, b}, {fdc_d_oe, fdc_d_o});
        @(posedge aclk);
        fdc_drq <= 1'b0;
        #1;
        chk("dack end", 32'h0, {31'h0, fdc_dack});
    endtask

    // ==========================================
    // scenarios
    task automatic t_regs();
        logic [7:0] rd;
        logic [31:0] v;
        logic [1:0] r;
        loc(1'b0, RB + 32'h4, 8'h00, rd);
        chk("dma reg reset", {24'h0, fbdm_pkg::DMA_RESET}, {24'h0, rd});
        chk("okay bresp", {30'h0, fbdm_pkg::RESP_OKAY}, {30'h0, bresp_q});
        loc(1'b1, RB + 32'h4, 8'h03, rd);
        loc(1'b0, RB + 32'h4, 8'h00, rd);
        chk("dir busy", 32'h1, {30'h0, rd[1:0]});
        loc(1'b1, RB + 32'h4, 8'h00, rd);
        loc(1'b0, RB + 32'h4, 8'h00, rd);
        chk("dir clear", 32'h0, {30'h0, rd[1:0]});
        axi_read(5'h18, v, r);
        chk("unmapped rresp", {30'h0, fbdm_pkg::RESP_SLVERR}, {30'h0, r});
        chk("unmapped rdata", 32'h0, v);
        axi_write(5'h1c, 32'h1);
        chk("unmapped bresp", {30'h0, fbdm_pkg::RESP_SLVERR}, {30'h0, bresp_q});
    endtask

    task automatic t_fdc_regs();
        logic [7:0] rd;
        for (int k = 0; k < 4; k++) begin
            loc(1'b1, RB + k, 8'h30 + k[7:0], rd);
            chk("fdc write", {22'h0, k[1:0], 8'h30 + k[7:0]}, {22'h0, wr_a, wr_d});
            if (k < 3) begin
                fdc_byte <= 8'hc0 + k[7:0];
                loc(1'b0, RB + k, 8'h00, rd);
                chk("fdc read", {24'h0, 8'hc0 + k[7:0]}, {24'h0, rd});
            end
        end
    endtask

    task automatic t_buffer();
        logic [7:0] rd;
        logic [31:0] ba [3] = '{BB, BB + 32'h1234, fbdm_pkg::BUF_LAST};
        for (int k = 0; k < 3; k++) loc(1'b1, ba[k], 8'ha0 + k[7:0], rd);
        for (int k = 0; k < 3; k++) begin
            loc(1'b0, ba[k], 8'h00, rd);
            chk("buffer", {24'h0, 8'ha0 + k[7:0]}, {24'h0, rd});
        end
        loc(1'b0, BB + 32'h4000, 8'h00, rd);
        chk("past buffer", 32'h0, {24'h0, rd});
    endtask

    task automatic t_dma_read();
        logic [7:0] rd;
        logic [7:0] vals [3] = '{8'h5a, 8'ha5, 8'h3c};
        logic [31:0] v;
        logic [1:0] r;
        loc(1'b1, RB + 32'h4, 8'h00, rd);
        axi_write(fbdm_pkg::A_IRQ_MASK, 32'h0);
        axi_write(fbdm_pkg::A_IRQ_STAT, 32'h3);
        dma_byte(vals[0], 1'b0);
        loc(1'b0, RB + 32'h4, 8'h00, rd);
        chk("busy", 32'h2, {30'h0, rd[1:0]});
        for (int k = 1; k < 3; k++) dma_byte(vals[k], 1'b0);
        @(posedge aclk);
        fdc_int <= 1'b1;
        repeat (2) @(posedge aclk);
        #1;
        chk("irq1", 32'h1, {31'h0, u_fbdm_lport_if.irq1});
        chk("irq masked", 32'h0, {31'h0, irq});
        axi_read(fbdm_pkg::A_IRQ_STAT, v, r);
        chk("irq status", 32'h1, {31'h0, v[fbdm_pkg::IRQ_FDC]});
        axi_write(fbdm_pkg::A_IRQ_MASK, 32'h2);
        @(posedge aclk);
        #1;
        chk("irq on", 32'h1, {31'h0, irq});
        axi_write(fbdm_pkg::A_IRQ_STAT, 32'h2);
        @(posedge aclk);
        fdc_int <= 1'b0;
        #1;
        chk("irq cleared", 32'h0, {31'h0, irq});
        loc(1'b0, RB + 32'h4, 8'h00, rd);
        chk("busy end", 32'h0, {30'h0, rd[1:0]});
        for (int k = 0; k < 3; k++) begin
            loc(1'b0, BB + k, 8'h00, rd);
            chk("dma stored", {24'h0, vals[k]}, {24'h0, rd});
        end
    endtask

    task automatic t_dma_write();
        logic [7:0] rd;
        logic [7:0] vals [3] = '{8'h81, 8'h7e, 8'hff};
        int n0;
        for (int k = 0; k < 3; k++) loc(1'b1, BB + k, vals[k], rd);
        loc(1'b1, RB + 32'h4, 8'h01, rd);
        for (int k = 0; k < 3; k++) dma_byte(vals[k], 1'b1);
        loc(1'b0, RB + 32'h4, 8'h00, rd);
        chk("dma write busy", 32'h3, {30'h0, rd[1:0]});
        n0 = tc_cnt;
        loc(1'b0, RB + 32'h5, 8'h00, rd);
        chk("tc cycles", 32'h2, tc_cnt - n0);
        chk("tc released", 32'h0, {31'h0, terminal_count_strobe});
        loc(1'b0, RB + 32'h4, 8'h00, rd);
        chk("tc ends dma", 32'h1, {30'h0, rd[1:0]});
    endtask

    // reset in mid-run while a transfer is marked busy and dir is set
    task automatic t_reset();
        logic [7:0] rd;
        dma_byte(8'h81, 1'b1);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        loc(1'b0, RB + 32'h4, 8'h00, rd);
        chk("dma reg rst2", {24'h0, fbdm_pkg::DMA_RESET}, {24'h0, rd});
    endtask

    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_fdc_regs();
        t_buffer();
        t_dma_read();
        t_dma_write();
        t_reset();
        print_verdict();
    end
endmodule // tb_floppy_buffer_dma_manager
